// >>> mps_defines.vh
// constants for the multiphase pwm sequencer
`ifndef MPS_DEFINES_VH
`define MPS_DEFINES_VH
`define MPS_MAX_PHASES     3'h4
`define MPS_DETECT_CYCLES  2'h2
`define MPS_OSC_DIV        16'h0064
`define MPS_PHASE_DIV      8'h40
`define MPS_SS_STEP        16'h0001
`define MPS_SS_FULL        16'hFFFF
`define MPS_VCODE_NOCPU    5'h1F
`define MPS_VCODE_LSB_UV   16'h30D4
`define MPS_VREF_TOP       16'h3E80
`define MPS_VREF_STEP      16'h007D
`define MPS_KEY_TOP        6'h15
`define MPS_KEY_WRAP       6'h29
`endif

// >>> mps_sequencer.v
// multiphase pwm sequencer: phase detect, rotation, pwm, soft start, voltage code
`timescale 1ns/1ps
`include "mps_defines.vh"
module mps_sequencer #(
  parameter OSC_DIV   = `MPS_OSC_DIV,
  parameter PHASE_DIV = `MPS_PHASE_DIV,
  parameter SS_STEP   = `MPS_SS_STEP
) (
  // clock and reset
  input  wire        MCLK_IN,
  input  wire        SYS_RST_IN,
  // enable and supply status, asynchronous pins
  input  wire        ENABLE_IN,
  input  wire        SUPPLY_LOW_LOCKOUT_IN,
  input  wire        OUTPUT_GOOD_FLAG_IN,
  // phase3/phase4 detect comparators, high when above threshold
  input  wire        PHASE3_SENSE_IN,
  input  wire        PHASE4_SENSE_IN,
  // per-phase duty, in master cycles of the phase period
  input  wire [31:0] DUTY_IN,
  // voltage code from processor
  input  wire [5:0]  VOLTAGE_CODE_IN,
  // phase outputs and weak detection drive
  output reg  [3:0]  PHASE_OUTPUT_OUT,
  output reg         DETECT_DRIVE_OUT,
  // soft-start node, reference and status
  output reg  [15:0] SOFT_START_OUT,
  output reg  [15:0] REFERENCE_MV10_OUT,
  output reg         NO_CPU_OUT,
  output reg  [2:0]  PHASE_COUNT_OUT,
  output reg         SOFT_START_DONE_OUT
);
  localparam ST_OFF    = 3'b001;
  localparam ST_DETECT = 3'b010;
  localparam ST_RUN    = 3'b100;

  // two flip-flop synchronisers
  reg [4:0] sync1_reg;
  reg [4:0] sync2_reg;
  always @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
    end
    else
    begin
      sync1_reg <= {PHASE4_SENSE_IN, PHASE3_SENSE_IN, OUTPUT_GOOD_FLAG_IN,
                    SUPPLY_LOW_LOCKOUT_IN, ENABLE_IN};
      sync2_reg <= sync1_reg;
    end
  end
  // enable high and supply out of lockout
  wire run_ok  = sync2_reg[0] & ~sync2_reg[1];
  wire good_s  = sync2_reg[2];
  wire p3_up_s = sync2_reg[3];
  wire p4_up_s = sync2_reg[4];

  // code to reference in units of 0.1 mV; keys 62 and 63 are the no-cpu pair
  function [15:0] code_to_ref;
    input [5:0] code;
    reg   [5:0]  key;
    reg   [5:0]  step;
    reg   [15:0] drop;
    begin
      key = {code[4:0], code[5]};
      // top voltage at key 21, counting down and wrapping past no-cpu
      if (key >= `MPS_KEY_TOP)
        step = key - `MPS_KEY_TOP;
      else
        step = key + `MPS_KEY_WRAP;
      drop        = {10'h000, step} * `MPS_VREF_STEP;
      code_to_ref = `MPS_VREF_TOP - drop;
    end
  endfunction

  // last count of a phase period: phase div slots times phase count
  function [7:0] period_last;
    input [2:0] count;
    reg   [15:0] span;
    begin
      span        = PHASE_DIV * {13'h0000, count};
      period_last = span[7:0] - 8'h01;
    end
  endfunction

  // oscillator, detection and phase state
  reg [2:0]  state_reg;
  reg [15:0] osc_cnt_reg;
  reg [1:0]  osc_cycles_reg;
  reg [3:0]  fitted_reg;
  reg [7:0]  ph_cnt_reg [0:3];
  reg [1:0]  start_idx_reg;
  reg [3:0]  started_reg;
  wire       osc_tick = (osc_cnt_reg == OSC_DIV - 16'h0001);
  integer    i;

  // last slot count for the detected phase count
  wire [7:0] slot_last = period_last(PHASE_COUNT_OUT);

  // detection, rotation and pwm state machine
  always @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN || !run_ok)
    begin
      // disabled: hold outputs and ramp at ground
      state_reg           <= ST_OFF;
      osc_cnt_reg         <= 16'h0000;
      osc_cycles_reg      <= 2'h0;
      fitted_reg          <= 4'h0;
      start_idx_reg       <= 2'h0;
      started_reg         <= 4'h0;
      PHASE_OUTPUT_OUT    <= 4'h0;
      DETECT_DRIVE_OUT    <= 1'b0;
      SOFT_START_OUT      <= 16'h0000;
      SOFT_START_DONE_OUT <= 1'b0;
      PHASE_COUNT_OUT     <= 3'h0;
      for (i = 0; i < 4; i = i + 1)
        ph_cnt_reg[i] <= 8'h00;
    end
    else
    begin
      osc_cnt_reg <= osc_tick ? 16'h0000 : osc_cnt_reg + 16'h0001;
      case (state_reg)
        ST_OFF:
        begin
          // arm the weak detection drive
          DETECT_DRIVE_OUT <= 1'b1;
          osc_cycles_reg   <= 2'h0;
          state_reg        <= ST_DETECT;
        end
        ST_DETECT:
        begin
          // count oscillator cycles of the window
          if (osc_tick)
            osc_cycles_reg <= osc_cycles_reg + 2'h1;
          if (osc_tick && osc_cycles_reg == `MPS_DETECT_CYCLES - 2'h1)
          begin
            // window closed: fix the phase count
            DETECT_DRIVE_OUT <= 1'b0;
            // phase4 grounded -> 3, both -> 2
            fitted_reg <= {p4_up_s & p3_up_s, p3_up_s, 2'b11};
            PHASE_COUNT_OUT <= p3_up_s ? (p4_up_s ? 3'h4 : 3'h3) : 3'h2;
            state_reg <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          // rotating start, one phase per clock
          if (started_reg != fitted_reg)
          begin
            started_reg[start_idx_reg] <= fitted_reg[start_idx_reg];
            start_idx_reg <= start_idx_reg + 2'h1;
          end
          // per-phase counters; duty compare gives the pulse
          for (i = 0; i < 4; i = i + 1)
          begin
            if (started_reg[i] && fitted_reg[i])
            begin
              // period = phase div times phase count
              if (ph_cnt_reg[i] == slot_last)
                ph_cnt_reg[i] <= 8'h00;
              else
                ph_cnt_reg[i] <= ph_cnt_reg[i] + 8'h01;
              PHASE_OUTPUT_OUT[i] <= (ph_cnt_reg[i] < DUTY_IN[i*8 +: 8]);
            end
            else
              PHASE_OUTPUT_OUT[i] <= 1'b0;
          end
          // jump the ramp to full scale and set done once the output is good
          if (good_s)
          begin
            SOFT_START_OUT      <= `MPS_SS_FULL;
            SOFT_START_DONE_OUT <= 1'b1;
          end
          else if (!SOFT_START_DONE_OUT && SOFT_START_OUT < `MPS_SS_FULL - SS_STEP)
            SOFT_START_OUT <= SOFT_START_OUT + SS_STEP;
        end
        default:
          state_reg <= ST_OFF;
      endcase
    end
  end

  // reference follows code scaled by soft-start ramp
  wire [15:0] ref_full = code_to_ref(VOLTAGE_CODE_IN);
  wire [31:0] ref_prod = ref_full * SOFT_START_OUT;
  // no processor forces a zero reference
  wire        no_cpu   = (VOLTAGE_CODE_IN[4:0] == `MPS_VCODE_NOCPU);
  always @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      REFERENCE_MV10_OUT <= 16'h0000;
      NO_CPU_OUT         <= 1'b0;
    end
    else
    begin
      NO_CPU_OUT <= no_cpu;
      if (no_cpu)
        REFERENCE_MV10_OUT <= 16'h0000;
      else
        REFERENCE_MV10_OUT <= ref_prod[31:16];
    end
  end
endmodule // mps_sequencer

// >>> mps_sequencer_sva.sv
// assertions on the sequencer ports
`timescale 1ns/1ps
module mps_sequencer_sva (
  input wire        MCLK_IN,
  input wire        SYS_RST_IN,
  input wire        ENABLE_IN,
  input wire [5:0]  VOLTAGE_CODE_IN,
  input wire [3:0]  PHASE_OUTPUT_OUT,
  input wire        DETECT_DRIVE_OUT,
  input wire [15:0] SOFT_START_OUT,
  input wire [15:0] REFERENCE_MV10_OUT,
  input wire        NO_CPU_OUT,
  input wire [2:0]  PHASE_COUNT_OUT,
  input wire        SOFT_START_DONE_OUT
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  off_low_a: assert property (!ENABLE_IN [*4] |=> PHASE_OUTPUT_OUT == 4'h0)
    else $error("phase on while off");
  ramp_clear_a: assert property (!ENABLE_IN [*4] |=> SOFT_START_OUT == 16'h0000)
    else $error("ramp not cleared");
  count_legal_a: assert property (PHASE_COUNT_OUT != 3'h0 |-> PHASE_COUNT_OUT > 3'h1)
    else $error("bad phase count");
  count_held_a: assert property (PHASE_COUNT_OUT != 3'h0 && ENABLE_IN
    |=> (PHASE_COUNT_OUT == 3'h0 || PHASE_COUNT_OUT == $past(PHASE_COUNT_OUT)))
    else $error("phase count moved");
  two_off_a: assert property (PHASE_COUNT_OUT == 3'h2 |-> PHASE_OUTPUT_OUT[3:2] == 2'h0)
    else $error("grounded phase on");
  three_off_a: assert property (PHASE_COUNT_OUT == 3'h3 |-> !PHASE_OUTPUT_OUT[3])
    else $error("grounded phase on");
  detect_quiet_a: assert property (DETECT_DRIVE_OUT |-> PHASE_COUNT_OUT == 3'h0)
    else $error("detect after count");
  full_ramp_a: assert property (SOFT_START_DONE_OUT |-> SOFT_START_OUT == 16'hFFFF)
    else $error("ramp not full");
  no_cpu_a: assert property ((VOLTAGE_CODE_IN[4:0] == 5'h1F) [*3] |-> NO_CPU_OUT)
    else $error("no cpu missed");
  ref_zero_a: assert property (NO_CPU_OUT [*2] |-> REFERENCE_MV10_OUT == 16'h0000)
    else $error("reference kept");
  cover property (PHASE_COUNT_OUT == 3'h3);
  cover property (PHASE_COUNT_OUT == 3'h2);
  cover property (SOFT_START_DONE_OUT);
endmodule // mps_sequencer_sva
bind mps_sequencer mps_sequencer_sva mps_sequencer_sva_i (.*);

// >>> mps_gate_model.sv
// gate driver pins: grounded pins read low
`timescale 1ns/1ps
module mps_gate_model (
  input  wire [3:0] phase_in,
  input  wire       detect_in,
  input  wire [1:0] grounded_in,
  output wire       sense3_out,
  output wire       sense4_out
);
  assign sense3_out = ~grounded_in[0] & (detect_in | phase_in[2]);
  assign sense4_out = ~grounded_in[1] & (detect_in | phase_in[3]);
endmodule // mps_gate_model

// >>> tb_mps_sequencer.sv
// testbench for the sequencer
`timescale 1ns/1ps
module tb_mps_sequencer;
  reg         clk = 0, rst = 1, en = 0, lo = 0, good = 0;
  reg  [1:0]  gnd = 0;
  reg  [5:0]  code = 6'h0A;
  wire        s3, s4, dd, nc, sd;
  wire [3:0]  po;
  wire [2:0]  pc;
  wire [15:0] ss, rf;
  integer     err_total = 0, checks_done = 0, cyc = 0, t0;
  always #2 clk = ~clk;
  mps_gate_model mps_gate_model_i (.phase_in(po), .detect_in(dd), .grounded_in(gnd),
    .sense3_out(s3), .sense4_out(s4));
  mps_sequencer #(.OSC_DIV(16'h0004)) mps_sequencer_i (.MCLK_IN(clk), .SYS_RST_IN(rst),
    .ENABLE_IN(en), .SUPPLY_LOW_LOCKOUT_IN(lo), .OUTPUT_GOOD_FLAG_IN(good),
    .PHASE3_SENSE_IN(s3), .PHASE4_SENSE_IN(s4), .DUTY_IN(32'h1010_1010),
    .VOLTAGE_CODE_IN(code), .PHASE_OUTPUT_OUT(po), .DETECT_DRIVE_OUT(dd),
    .SOFT_START_OUT(ss), .REFERENCE_MV10_OUT(rf), .NO_CPU_OUT(nc),
    .PHASE_COUNT_OUT(pc), .SOFT_START_DONE_OUT(sd));
  task stop_test;
    if (err_total == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input [63:0] nm, input [15:0] e, input [15:0] g);
    begin
      checks_done = checks_done + 1;
      if (e !== g)
      begin
        err_total = err_total + 1;
        $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task t_phases(input [1:0] g, input [2:0] c);
    begin
      en <= 0;
      gnd <= g;
      repeat (6) @(posedge clk);
      en <= 1;
      repeat (24) @(posedge clk);
      chk("count", {13'h0, c}, {13'h0, pc});
      @(posedge po[0]) t0 = cyc;
      @(posedge po[0]) chk("period", 16'h0040 * c, cyc - t0);
    end
  endtask
  task t_soft;
    begin
      good <= 1;
      repeat (4) @(posedge clk);
      chk("full", 16'hFFFF, ss);
      @(posedge clk);
      chk("ref", 16'h20B6, rf);
      lo <= 1;
      repeat (5) @(posedge clk);
      chk("cleared", 16'h0000, ss);
      chk("outs", 16'h0000, {12'h0, po});
      good <= 0;
      lo <= 0;
      repeat (12) @(posedge clk);
      chk("rising", 16'h0001, {15'h0, ss != 16'h0000});
    end
  endtask
  task t_code;
    begin
      code <= 6'h1F;
      repeat (5) @(posedge clk);
      chk("nocpu", 16'h0001, {15'h0, nc});
      chk("ref", 16'h0000, rf);
    end
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      err_total = err_total + 1;
      stop_test;
    end
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 0;
    t_phases(2'b00, 3'h4);
    t_phases(2'b10, 3'h3);
    t_phases(2'b11, 3'h2);
    t_soft;
    t_code;
    stop_test;
  end
endmodule // tb_mps_sequencer
